// File: adtrs_pkg.sv
package adtrs_pkg;
	// Register addresses on the serial link
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_TRIM1 = 5'h0f;
	localparam logic [4:0] ADDR_TRIM2 = 5'h10;
	localparam logic [4:0] ADDR_TRIM3 = 5'h11;
	localparam logic [4:0] ADDR_TEST = 5'h1f;
	// Field positions
	localparam int FILT_LSB = 4;
	localparam int INTERNAL_CURRENT_REFERENCE_LSB = 0;
	localparam int COARSE_LSB = 6;
	localparam int FINE_HI_LSB = 3;
	localparam int FINE_LO_LSB = 0;
	// Reset values
	localparam logic [7:0] TRIM_RST = 8'h00;
	localparam logic [1:0] FILT_RST = 2'h0;
	// Frame length
	localparam logic [4:0] FRAME_BITS = 5'h10;
	// Fine trim codes
	localparam logic [2:0] FINE_RSVD = 3'h4;
	localparam logic [2:0] FINE_NONE = 3'h0;
	// Overcurrent filter delays in microseconds, code order 0..3
	localparam int FILT_US_0 = 950;
	localparam int FILT_US_1 = 536;
	localparam int FILT_US_2 = 234;
	localparam int FILT_US_3 = 78;
	localparam int CLK_MHZ = 250;
	localparam int FILT_CYC_0 = FILT_US_0 * CLK_MHZ;
	localparam int FILT_CYC_3 = FILT_US_3 * CLK_MHZ;
endpackage

// File: adtrs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module adtrs_slave (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_ss_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic [7:0] i_sys_status,
	output logic [1:0] o_supply_overcurrent_filter_sel,
	output logic [3:0] o_current_reference_trim,
	output logic [1:0] o_bridge12_coarse_sense_trim,
	output logic [2:0] o_bridge34_fine_sense_trim,
	output logic [2:0] o_bridge12_fine_sense_trim,
	output logic [1:0] o_bridge34_coarse_sense_trim,
	output logic [2:0] o_highside23_sense_trim,
	output logic [2:0] o_highside1_sense_trim,
	output logic o_frame_done,
	output logic o_frame_error
);
	import adtrs_pkg::*;

	// Reserved fine code acts as no adjustment
	function automatic logic [2:0] fine_eff(input logic [2:0] c);
		fine_eff = (c == FINE_RSVD) ? FINE_NONE : c;
	endfunction

	// Three-stage sync; decisions use stages two and three only
	logic [2:0] sck_s_q, sck_s_d, ss_s_q, ss_s_d, mo_s_q, mo_s_d;
	always_comb begin
		sck_s_d = {sck_s_q[1:0], i_sclk};
		ss_s_d = {ss_s_q[1:0], i_ss_n};
		mo_s_d = {mo_s_q[1:0], i_mosi};
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sck_s_q <= 3'h0;
			ss_s_q <= 3'h7;
			mo_s_q <= 3'h0;
		end else begin
			sck_s_q <= sck_s_d;
			ss_s_q <= ss_s_d;
			mo_s_q <= mo_s_d;
		end
	end
	logic sck_rise, sck_fall, ss_fall, ss_rise, ss_act, mo_bit;
	assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
	assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
	assign ss_fall = ~ss_s_q[1] & ss_s_q[2];
	assign ss_rise = ss_s_q[1] & ~ss_s_q[2];
	assign ss_act = ~ss_s_q[2];
	assign mo_bit = mo_s_q[2];

	// Register bank
	logic [7:0] trim1_q, trim1_d, trim2_q, trim2_d, trim3_q, trim3_d;
	// Frame state
	logic [15:0] rx_q, rx_d;
	logic [15:0] tx_q, tx_d;
	logic [5:0] cnt_q, cnt_d;
	logic miso_q, miso_d, oe_q, oe_d, done_q, done_d, err_q, err_d;

	function automatic logic [7:0] read_reg(input logic [4:0] a, input logic [7:0] st, input logic [7:0] t1);
		if (a == ADDR_STATUS)
			read_reg = st;
		else if (a == ADDR_TRIM1)
			read_reg = {t1[FILT_LSB +: 2], 6'h00} >> 2;
		else
			read_reg = 8'h00;
	endfunction

	logic [4:0] addr_w;
	logic rw_w, par_ok;
	assign rw_w = rx_q[15];
	assign addr_w = rx_q[14:10];
	assign par_ok = ~^rx_q[15:9];

	always_comb begin
		rx_d = rx_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		miso_d = miso_q;
		oe_d = ss_act;
		done_d = 1'b0;
		err_d = 1'b0;
		trim1_d = trim1_q;
		trim2_d = trim2_q;
		trim3_d = trim3_q;
		if (ss_fall) begin
			cnt_d = 6'h00;
			tx_d = {i_sys_status, 8'h00};
			miso_d = 1'b0;
		end else if (ss_act) begin
			if (sck_rise) begin
				miso_d = tx_q[15];
				tx_d = {tx_q[14:0], 1'b0};
			end
			if (sck_fall) begin
				rx_d = {rx_q[14:0], mo_bit};
				if (cnt_q != 6'h3f)
					cnt_d = cnt_q + 6'h01;
				// Latched with the parity bit; seven reply bits have shifted out, so the slot is 14:7
				if (cnt_q == 6'h06)
					tx_d[14:7] = read_reg(rx_q[4:0], i_sys_status, trim1_q);
			end
		end
		if (ss_rise) begin
			done_d = 1'b1;
			miso_d = 1'b0;
			if (cnt_q != {1'b0, FRAME_BITS}) begin
				err_d = 1'b1;
			end else if (!rw_w) begin
				if (!par_ok) begin
					err_d = 1'b1;
				end else if (addr_w == ADDR_TRIM1) begin
					trim1_d = {2'h0, rx_q[FILT_LSB +: 2], rx_q[INTERNAL_CURRENT_REFERENCE_LSB +: 4]};
				end else if (addr_w == ADDR_TRIM2) begin
					trim2_d = rx_q[7:0];
				end else if (addr_w == ADDR_TRIM3) begin
					trim3_d = rx_q[7:0];
				end
				// Test register write is dropped: factory only
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			trim1_q <= TRIM_RST;
			trim2_q <= TRIM_RST;
			trim3_q <= TRIM_RST;
			rx_q <= 16'h0000;
			tx_q <= 16'h0000;
			cnt_q <= 6'h00;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			trim1_q <= trim1_d;
			trim2_q <= trim2_d;
			trim3_q <= trim3_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			miso_q <= miso_d;
			oe_q <= oe_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	// Field outputs; a second flop stage keeps outputs straight from flops
	logic [21:0] out_q, out_d;
	always_comb begin
		out_d = {trim1_q[FILT_LSB +: 2], trim1_q[INTERNAL_CURRENT_REFERENCE_LSB +: 4],
			trim2_q[COARSE_LSB +: 2], fine_eff(trim2_q[FINE_HI_LSB +: 3]), fine_eff(trim2_q[FINE_LO_LSB +: 3]),
			trim3_q[COARSE_LSB +: 2], fine_eff(trim3_q[FINE_HI_LSB +: 3]), fine_eff(trim3_q[FINE_LO_LSB +: 3])};
	end
	always_ff @(posedge i_clk) begin
		if (i_rst)
			out_q <= 22'h000000;
		else
			out_q <= out_d;
	end
	assign o_supply_overcurrent_filter_sel = out_q[21:20];
	assign o_current_reference_trim = out_q[19:16];
	assign o_bridge12_coarse_sense_trim = out_q[15:14];
	assign o_bridge34_fine_sense_trim = out_q[13:11];
	assign o_bridge12_fine_sense_trim = out_q[10:8];
	assign o_bridge34_coarse_sense_trim = out_q[7:6];
	assign o_highside23_sense_trim = out_q[5:3];
	assign o_highside1_sense_trim = out_q[2:0];
	assign o_miso = miso_q;
	assign o_miso_oe = oe_q;
	assign o_frame_done = done_q;
	assign o_frame_error = err_q;

	property p_reset_clear;
		@(posedge i_clk) i_rst |=> (trim1_q == 8'h00 && trim2_q == 8'h00 && trim3_q == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("trim not cleared");

	property p_filt_rst;
		@(posedge i_clk) i_rst |=> ##1 o_supply_overcurrent_filter_sel == FILT_RST;
	endproperty
	a_filt_rst: assert property (p_filt_rst) else $error("filter not reset");

	property p_short_frame;
		@(posedge i_clk) disable iff (i_rst) (ss_rise && cnt_q != 6'h10) |=> err_q && $stable(trim2_q);
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("bad frame accepted");

	property p_store_only_end;
		@(posedge i_clk) disable iff (i_rst) !ss_rise |=> $stable(trim3_q);
	endproperty
	a_store_only_end: assert property (p_store_only_end) else $error("store outside select edge");

	property p_parity;
		@(posedge i_clk) disable iff (i_rst)
			(ss_rise && cnt_q == 6'h10 && !rw_w && !par_ok) |=> err_q && $stable(trim1_q);
	endproperty
	a_parity: assert property (p_parity) else $error("bad parity stored");

	property p_status_first;
		@(posedge i_clk) disable iff (i_rst) ss_fall |=> tx_q[15:8] == $past(i_sys_status);
	endproperty
	a_status_first: assert property (p_status_first) else $error("status not first");

	// A complete write frame with good parity, seen at the select rising edge
	sequence s_good_write;
		ss_rise && cnt_q == 6'h10 && !rw_w && par_ok;
	endsequence
	property p_store_t2;
		@(posedge i_clk) disable iff (i_rst)
			(s_good_write ##0 (addr_w == ADDR_TRIM2)) |=> trim2_q == $past(rx_q[7:0]);
	endproperty
	a_store_t2: assert property (p_store_t2) else $error("trim2 not stored");

	property p_rsvd;
		@(posedge i_clk) disable iff (i_rst) trim3_q[2:0] == FINE_RSVD |=> o_highside1_sense_trim == FINE_NONE;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code used");

	sequence s_read_latch;
		ss_act && sck_fall && cnt_q == 6'h06;
	endsequence
	property p_wo_zero;
		@(posedge i_clk) disable iff (i_rst) (s_read_latch ##0 (rx_q[4:0] == ADDR_TRIM3)) |=> tx_q[14:7] == 8'h00;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("write-only readback");

	// Status and filter readback land in the reply's data slot
	property p_read_status;
		@(posedge i_clk) disable iff (i_rst)
			(s_read_latch ##0 (rx_q[4:0] == ADDR_STATUS)) |=> tx_q[14:7] == $past(i_sys_status);
	endproperty
	a_read_status: assert property (p_read_status) else $error("status readback wrong");

	property p_read_filt;
		@(posedge i_clk) disable iff (i_rst)
			(s_read_latch ##0 (rx_q[4:0] == ADDR_TRIM1)) |=> tx_q[14:7] == {2'h0, $past(trim1_q[FILT_LSB +: 2]), 4'h0};
	endproperty
	a_read_filt: assert property (p_read_filt) else $error("filter readback wrong");

	property p_read_no_store;
		@(posedge i_clk) disable iff (i_rst)
			(ss_rise && rw_w) |=> $stable(trim1_q) && $stable(trim2_q) && $stable(trim3_q);
	endproperty
	a_read_no_store: assert property (p_read_no_store) else $error("read frame stored");

	property p_test_dropped;
		@(posedge i_clk) disable iff (i_rst)
			(ss_rise && addr_w == ADDR_TEST) |=> $stable(trim1_q) && $stable(trim2_q) && $stable(trim3_q);
	endproperty
	a_test_dropped: assert property (p_test_dropped) else $error("test register frame stored");

	property p_store_t1;
		@(posedge i_clk) disable iff (i_rst)
			(s_good_write ##0 (addr_w == ADDR_TRIM1)) |=> trim1_q == {2'h0, $past(rx_q[5:0])};
	endproperty
	a_store_t1: assert property (p_store_t1) else $error("trim1 not stored");

	property p_store_t3;
		@(posedge i_clk) disable iff (i_rst)
			(s_good_write ##0 (addr_w == ADDR_TRIM3)) |=> trim3_q == $past(rx_q[7:0]);
	endproperty
	a_store_t3: assert property (p_store_t3) else $error("trim3 not stored");

	// Field outputs trail the register bank by one clock
	property p_field_pass;
		@(posedge i_clk) disable iff (i_rst)
			1'b1 |=> o_supply_overcurrent_filter_sel == $past(trim1_q[FILT_LSB +: 2])
				&& o_current_reference_trim == $past(trim1_q[INTERNAL_CURRENT_REFERENCE_LSB +: 4]);
	endproperty
	a_field_pass: assert property (p_field_pass) else $error("trim1 fields not driven");

	property p_coarse_pass;
		@(posedge i_clk) disable iff (i_rst)
			1'b1 |=> o_bridge12_coarse_sense_trim == $past(trim2_q[COARSE_LSB +: 2])
				&& o_bridge34_coarse_sense_trim == $past(trim3_q[COARSE_LSB +: 2]);
	endproperty
	a_coarse_pass: assert property (p_coarse_pass) else $error("coarse trim not driven");

	property p_b34_rsvd;
		@(posedge i_clk) disable iff (i_rst)
			trim2_q[FINE_HI_LSB +: 3] == FINE_RSVD |=> o_bridge34_fine_sense_trim == FINE_NONE;
	endproperty
	a_b34_rsvd: assert property (p_b34_rsvd) else $error("reserved bridge code used");

	property p_b12_pass;
		@(posedge i_clk) disable iff (i_rst)
			trim2_q[FINE_LO_LSB +: 3] != FINE_RSVD |=> o_bridge12_fine_sense_trim == $past(trim2_q[FINE_LO_LSB +: 3]);
	endproperty
	a_b12_pass: assert property (p_b12_pass) else $error("bridge fine trim not driven");

	property p_hs23_pass;
		@(posedge i_clk) disable iff (i_rst)
			trim3_q[FINE_HI_LSB +: 3] != FINE_RSVD |=> o_highside23_sense_trim == $past(trim3_q[FINE_HI_LSB +: 3]);
	endproperty
	a_hs23_pass: assert property (p_hs23_pass) else $error("high side trim not driven");

	property p_done_once;
		@(posedge i_clk) disable iff (i_rst) ss_rise |=> o_frame_done ##1 !o_frame_done;
	endproperty
	a_done_once: assert property (p_done_once) else $error("frame done not a single pulse");

	// Reply line released once select is seen high
	property p_oe_release;
		@(posedge i_clk) disable iff (i_rst) $fell(ss_act) |=> !o_miso_oe;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("reply line still driven");
endmodule // adtrs_slave
`default_nettype wire

// File: adtrs_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module adtrs_spi_master (
	input wire logic i_clk,
	input wire logic i_miso,
	output logic o_sclk,
	output logic o_ss_n,
	output logic o_mosi
);
	initial begin
		o_sclk = 1'b0;
		o_ss_n = 1'b1;
		o_mosi = 1'b0;
	end
	// Six clocks per edge gives the 48 ns serial period
	task automatic step(input logic lvl);
		repeat (6) @(posedge i_clk);
		#1 o_sclk = lvl;
	endtask
	task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
		reply = 16'h0000;
		@(posedge i_clk);
		#1 o_ss_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			step(1'b1);
			o_mosi = (i < 16) ? word[15 - i] : 1'b0;
			step(1'b0);
			reply = {reply[14:0], i_miso};
		end
		step(1'b0);
		o_ss_n = 1'b1;
		// Pulled down once released
		o_mosi = 1'b0;
	endtask
endmodule // adtrs_spi_master
`default_nettype wire

// File: analog_die_trim_register_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module analog_die_trim_register_slave_bench;
	import adtrs_pkg::*;
	logic clk, rst, sclk, ss_n, mosi, miso, miso_oe, done, err, miso_w;
	logic [7:0] status, m_t1, m_t2, m_t3;
	logic [1:0] filt, b12c, b34c;
	logic [3:0] internal_current_reference;
	logic [2:0] b34f, b12f, hs23, hs1;
	int n_mismatch = 0;
	int samples_checked = 0;
	// Only status, trim and test registers are addressed
	logic [4:0] addrs [5] = '{ADDR_STATUS, ADDR_TRIM1, ADDR_TRIM2, ADDR_TRIM3, ADDR_TEST};
	// Released line must not echo the last bit
	assign miso_w = miso_oe ? miso : ~miso;
	adtrs_slave dut (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_ss_n(ss_n), .i_mosi(mosi), .o_miso(miso),
		.o_miso_oe(miso_oe), .i_sys_status(status), .o_supply_overcurrent_filter_sel(filt),
		.o_current_reference_trim(internal_current_reference), .o_bridge12_coarse_sense_trim(b12c), .o_bridge34_fine_sense_trim(b34f),
		.o_bridge12_fine_sense_trim(b12f), .o_bridge34_coarse_sense_trim(b34c), .o_highside23_sense_trim(hs23),
		.o_highside1_sense_trim(hs1), .o_frame_done(done), .o_frame_error(err));
	adtrs_spi_master master (.i_clk(clk), .i_miso(miso_w), .o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [2:0] fine(input logic [2:0] c);
		return (c == FINE_RSVD) ? FINE_NONE : c;
	endfunction
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic outs;
		chk("fields", {m_t1[5:4], m_t1[3:0], m_t2[7:6], fine(m_t2[5:3]), fine(m_t2[2:0]), m_t3[7:6],
			fine(m_t3[5:3]), fine(m_t3[2:0])}, {filt, internal_current_reference, b12c, b34f, b12f, b34c, hs23, hs1});
	endtask
	task automatic frame(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic badp, input int nb);
		logic [15:0] rep;
		logic [7:0] ex;
		logic e;
		int k;
		ex = (a == ADDR_STATUS) ? status : (a == ADDR_TRIM1) ? {2'b00, m_t1[5:4], 4'h0} : 8'h00;
		e = (nb != 16) || (!rw && badp);
		master.xfer({rw, a, ^{rw, a} ^ badp, 1'b0, d}, nb, rep);
		k = 0;
		while (done !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 40) begin
			n_mismatch++;
			complete_run();
		end
		chk("error", 22'(e), 22'(err));
		if (nb == 16) begin
			chk("status byte", 22'(status), 22'(rep[15:8]));
			chk("data byte", 22'(ex), 22'(rep[7:0]));
		end
		if (!e && !rw) begin
			if (a == ADDR_TRIM1) m_t1 = d;
			if (a == ADDR_TRIM2) m_t2 = d;
			if (a == ADDR_TRIM3) m_t3 = d;
		end
		repeat (2) @(posedge clk);
		#1 outs();
		chk("miso enable", 22'h000000, 22'(miso_oe));
	endtask
	task automatic do_reset;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		m_t1 = 8'h00;
		m_t2 = 8'h00;
		m_t3 = 8'h00;
		outs();
		repeat (4) @(posedge clk);
		#1 frame(1'b0, ADDR_TRIM1, 8'($urandom), 1'b0, 16);
		// Factory bytes carry reserved codes in the bridge34 fine and highside1 fields so those two fallbacks are always exercised
		frame(1'b0, ADDR_TRIM2, {2'($urandom), FINE_RSVD, 3'($urandom)}, 1'b0, 16);
		frame(1'b0, ADDR_TRIM3, {2'($urandom), 3'($urandom), FINE_RSVD}, 1'b0, 16);
	endtask
	initial begin
		logic [4:0] a;
		logic rw;
		int kind;
		rst = 1'b1;
		status = 8'h00;
		kind = $urandom(32'hec5a7311);
		do_reset();
		for (int n = 0; n < 60; n++) begin
			if (n == 30) do_reset();
			kind = $urandom % 5;
			a = addrs[$urandom % 5];
			rw = (kind == 2) || (a == ADDR_TEST);
			status = 8'($urandom);
			// Reads carry a random parity, which must not matter
			frame(rw, a, 8'($urandom), (kind == 3) || (kind == 2 && $urandom % 2 == 1),
				(kind == 4) ? 15 + 2 * ($urandom % 2) : 16);
		end
		complete_run();
	end
	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end
endmodule // analog_die_trim_register_slave_bench
`default_nettype wire
